// ===== bench/cgo_top_sva.sv
// port checker for cgo_top
// assumes one clk domain; bound to every cgo_top
module cgo_top_sva (
    // clock, reset, enable
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        ce,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // samples
    input wire logic        in_valid,
    input wire logic [1:0]  in_ch,
    input wire logic [23:0] in_data,
    input wire logic        out_valid,
    input wire logic [1:0]  out_ch,
    input wire logic [23:0] out_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctrl_r; // shift and enables
    // shadow control word, so pass-through can be judged
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            ctrl_r <= 8'h00;
        else if (ce && reg_wr && reg_addr == cgo_pkg::CTRL_ADDR)
            ctrl_r <= {reg_wdata[12:8], reg_wdata[2:0]};
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_take; ce && in_valid; endsequence
    sequence s_read; ce && reg_rd; endsequence
    a_take_answer: assert property (s_take |=> out_valid && out_ch == $past(in_ch))
        else $error("no answer to sample");
    a_no_extra: assert property (ce && !in_valid |=> !out_valid)
        else $error("out_valid without sample");
    a_data_hold: assert property (!(ce && in_valid) |=> $stable(out_data))
        else $error("out_data moved without sample");
    a_ch_hold: assert property (!(ce && in_valid) |=> $stable(out_ch))
        else $error("out_ch moved without sample");
    a_pass_thru: assert property (s_take ##0 ctrl_r[1:0] == 2'h0
        |=> out_data == $past(in_data))
        else $error("uncorrected sample altered");
    a_idle_rdata: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read");
    a_word_upper: assert property (s_read ##0 reg_addr[7:5] == 3'h0 |=> reg_rdata[31:24] == 8'h00)
        else $error("upper bits of word not zero");
    a_ctrl_read: assert property (s_read ##0 reg_addr == cgo_pkg::CTRL_ADDR
        |=> reg_rdata == {19'h0, ctrl_r[7:3], 5'h00, ctrl_r[2:0]})
        else $error("control read back wrong");
    a_freeze_out: assert property (!ce |=> $stable(out_valid) && $stable(reg_rdata))
        else $error("outputs moved while frozen");
endmodule : cgo_top_sva
bind cgo_top cgo_top_sva cgo_top_sva_inst (.clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .in_valid, .in_ch, .in_data, .out_valid, .out_ch, .out_data);

// ===== bench/cgo_top_test.sv
// self-checking bench for cgo_top
// assumes cgo_top_sva is bound in its own file
module cgo_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, arst_n, ce, reg_wr, reg_rd, in_valid, out_valid;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0]  in_ch, out_ch;
    logic [23:0] in_data, out_data;
    int          failures, num_checks;
    localparam logic [7:0] CT = cgo_pkg::CTRL_ADDR;
    cgo_top cgo_top_inst (.clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .in_valid, .in_ch, .in_data, .out_valid, .out_ch, .out_data);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk("reg_rdata", e, reg_rdata);
    endtask : rd
    task automatic smp(input logic [1:0] c, input logic [23:0] d, input logic [23:0] e);
        @(posedge clk);
        in_ch    <= c;
        in_data  <= d;
        in_valid <= 1'b1;
        @(posedge clk);
        in_valid <= 1'b0;
        #1;
        chk("out_valid", 32'h1, {31'h0, out_valid});
        chk("out_ch", {30'h0, c}, {30'h0, out_ch});
        chk("out_data", {8'h00, e}, {8'h00, out_data});
    endtask : smp
    task automatic t_reset;
        for (int i = 0; i < 4; i++)
        begin
            rd({4'h0, i[1:0], 2'h0}, 32'h007FFFFF);
            rd({4'h1, i[1:0], 2'h0}, 32'h00000000);
        end
        rd(CT, 32'h0);
        rd(8'h30, 32'h0);
    endtask : t_reset
    task automatic t_regs;
        wr(8'h04, 32'hFF800000);
        rd(8'h04, 32'h00800000);
        wr(8'h14, 32'h007FFFFF);
        rd(8'h14, 32'h007FFFFF);
    endtask : t_regs
    task automatic t_offset;
        wr(CT, 32'h2);
        wr(8'h14, 32'h10);
        smp(2'h1, 24'h000100, 24'h0000F0);
        smp(2'h1, 24'h800000, 24'h800000);
        rd(cgo_pkg::STAT_ADDR, 32'h2);
        wr(cgo_pkg::STAT_ADDR, 32'hF);
        rd(cgo_pkg::STAT_ADDR, 32'h0);
    endtask : t_offset
    task automatic t_gain;
        wr(CT, 32'h1);
        wr(8'h08, 32'h00400000);
        smp(2'h2, 24'h7FFFFF, 24'h400000);
        smp(2'h2, 24'hFFFF00, 24'hFFFF80);
        smp(2'h1, 24'h800000, 24'h7FFFFF);
    endtask : t_gain
    task automatic t_both;
        wr(CT, 32'h3);
        wr(8'h18, 32'h100);
        smp(2'h2, 24'h000300, 24'h000100);
    endtask : t_both
    task automatic t_cal;
        wr(CT, 32'h204);
        smp(2'h3, 24'h000100, 24'h000100);
        smp(2'h3, 24'h000100, 24'h000100);
        rd(8'h1C, 32'h70);
        wr(CT, 32'h0);
        smp(2'h3, 24'h000500, 24'h000500);
        rd(8'h1C, 32'h70);
        wr(CT, 32'h1804);
        smp(2'h0, 24'h800000, 24'h800000);
        rd(8'h10, 32'h00FFFFFF);
        rd(CT, 32'h1804);
    endtask : t_cal
    // low ce: a held sample answer, an ignored write and an ignored sample
    task automatic t_freeze;
        wr(CT, 32'h0);
        @(posedge clk);
        in_ch     <= 2'h2;
        in_data   <= 24'h000321;
        in_valid  <= 1'b1;
        @(posedge clk);
        ce        <= 1'b0;
        reg_addr  <= 8'h08;
        reg_wdata <= 32'h00000001;
        reg_wr    <= 1'b1;
        in_data   <= 24'h000456;
        @(posedge clk);
        reg_wr    <= 1'b0;
        in_valid  <= 1'b0;
        #1;
        chk("out_valid", 32'h1, {31'h0, out_valid});
        chk("out_data", 32'h321, {8'h00, out_data});
        @(posedge clk);
        ce        <= 1'b1;
        @(posedge clk);
        #1;
        chk("out_valid", 32'h0, {31'h0, out_valid});
        rd(8'h08, 32'h00400000);
    endtask : t_freeze
    task automatic print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    // 40 MHz filter clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // whole run needs well under 1000 cycles
    initial
    begin
        #(25 * 4000);
        failures++;
        print_verdict();
    end
    // main sequence
    initial
    begin
        {arst_n, reg_wr, reg_rd, in_valid, in_ch, in_data, reg_addr, reg_wdata} = '0;
        ce = 1'b1;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_regs();
        t_offset();
        t_gain();
        t_both();
        t_cal();
        t_freeze();
        print_verdict();
    end
endmodule : cgo_top_test

// ===== inc/cgo_calc_if.sv
// carrier between the top and the arithmetic datapath
// assumes the datapath is purely combinational
interface cgo_calc_if;
    logic        [23:0] sample;
    logic        [23:0] offset;
    logic        [23:0] gain;
    logic               gain_en;
    logic               offs_en;
    logic        [4:0]  shift;
    logic        [23:0] result;
    logic               sat;
    logic        [23:0] cal_next;

    modport calc (
        input  sample, offset, gain, gain_en, offs_en, shift,
        output result, sat, cal_next
    );
    modport ctl (
        output sample, offset, gain, gain_en, offs_en, shift,
        input  result, sat, cal_next
    );
endinterface : cgo_calc_if

// ===== inc/cgo_pkg.sv
// constants for the per-channel gain / offset correction stage
// assumes one filter clock; all data widths follow the 24-bit sample word
package cgo_pkg;
    localparam int          DW          = 24;
    localparam int          NCH         = 4;
    localparam int          CHW         = 2;
    localparam int          AW          = 8;
    localparam int          SHW         = 5;
    // register map, byte addresses
    localparam logic [3:0]  GAIN_REGION = 4'h0;
    localparam logic [3:0]  OFFS_REGION = 4'h1;
    localparam logic [7:0]  CTRL_ADDR   = 8'h20;
    localparam logic [7:0]  STAT_ADDR   = 8'h24;
    // control word fields
    localparam int          GAIN_EN_BIT = 0;
    localparam int          OFFS_EN_BIT = 1;
    localparam int          CAL_EN_BIT  = 2;
    localparam int          SHIFT_LSB   = 8;
    localparam logic [4:0]  SHIFT_MAX   = 5'h18;
    // code limits and reset values
    localparam logic [23:0] MAX_POS     = 24'h7FFFFF;
    localparam logic [23:0] MAX_NEG     = 24'h800000;
    localparam logic [23:0] GAIN_RST    = 24'h7FFFFF;
    localparam logic [23:0] OFFS_RST    = 24'h000000;
endpackage : cgo_pkg

// ===== logic/cgo_chan_calc.sv
// combinational correction and calibration arithmetic for one sample
// assumes operands are already selected for the sample's channel
module cgo_chan_calc (
    // operands and results
    cgo_calc_if.calc c
);
    logic signed [24:0] diff;
    logic signed [23:0] diff_sat;
    logic signed [47:0] prod;
    logic signed [47:0] quo;
    logic        [23:0] gain_out;
    logic               sat_offs;
    logic               sat_gain;
    logic        [4:0]  sh;
    logic signed [24:0] cdiff;
    logic signed [24:0] step;
    logic signed [24:0] cal_sum;

    // offset first, clipped to 24 bits
    assign diff     = c.offs_en ? ($signed({c.sample[23], c.sample})
                                   - $signed({c.offset[23], c.offset}))
                                : $signed({c.sample[23], c.sample});
    assign sat_offs = (diff[24] != diff[23]);
    assign diff_sat = sat_offs ? (diff[24] ? $signed(cgo_pkg::MAX_NEG)
                                           : $signed(cgo_pkg::MAX_POS))
                               : diff[23:0];

    // gain next: scale by gain / full positive code, truncates toward zero
    assign prod     = diff_sat * $signed(c.gain);
    assign quo      = prod / $signed({24'h000000, cgo_pkg::MAX_POS});
    // only full-negative times full-negative or minus full positive code overflows, still clip it
    assign sat_gain = (quo > $signed({24'h000000, cgo_pkg::MAX_POS}))
                    | (quo < $signed({24'hFFFFFF, cgo_pkg::MAX_NEG}));
    assign gain_out = sat_gain ? (quo[47] ? cgo_pkg::MAX_NEG : cgo_pkg::MAX_POS)
                               : quo[23:0];

    assign c.result = c.gain_en ? gain_out : diff_sat;
    assign c.sat    = sat_offs | (c.gain_en & sat_gain);

    // calibration: offset moves toward the raw sample by diff >> shift
    // out-of-range shifts are clamped rather than trusted
    assign sh       = (c.shift > cgo_pkg::SHIFT_MAX) ? cgo_pkg::SHIFT_MAX : c.shift;
    assign cdiff    = $signed({c.sample[23], c.sample}) - $signed({c.offset[23], c.offset});
    assign step     = cdiff >>> sh;
    // result lies between offset and sample, so it always fits 24 bits
    assign cal_sum  = $signed({c.offset[23], c.offset}) + step;
    assign c.cal_next = cal_sum[23:0];
endmodule : cgo_chan_calc

// ===== logic/cgo_top.sv
// gain / offset correction stage for four filter channels, with offset calibration
// assumes samples arrive on the filter clock, one per cycle at most, tagged by channel
module cgo_top (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // filtered samples in
    input  wire logic        in_valid,
    input  wire logic [1:0]  in_ch,
    input  wire logic [23:0] in_data,
    // corrected samples out
    output logic             out_valid,
    output logic      [1:0]  out_ch,
    output logic      [23:0] out_data
);
    localparam int NCH = cgo_pkg::NCH;
    localparam int CHW = cgo_pkg::CHW;

    // register map, one 32-bit word each, values in the low 24 bits
    //   gain word of channel i   : region 0, word index i in address bits 3:2
    //   offset word of channel i : region 1, word index i in address bits 3:2
    //   control word             : enables in bits 2:0, feedback shift in 12:8
    //   status word              : sticky clip flag per channel, write one to clear
    // address bits 1:0 are ignored inside a region, so byte aliases hit one word
    // unmapped reads return zero and unmapped writes are dropped
    // the upper byte of every word reads zero and is ignored on write

    cgo_calc_if cif ();

    logic [23:0]     gain_w [NCH];
    logic [23:0]     offs_w [NCH];
    logic [NCH-1:0]  sat_w;
    logic            gain_en_r;
    logic            offs_en_r;
    logic            cal_en_r;
    logic [4:0]      shift_r;
    logic [31:0]     rdata_r;
    logic [31:0]     rdata_nxt;
    logic            out_valid_r;
    logic [1:0]      out_ch_r;
    logic [23:0]     out_data_r;

    // address decode
    // plain combinational; reg_wr and reg_rd take effect only with ce high
    wire  [3:0]      region    = reg_addr[7:4];
    wire  [CHW-1:0]  reg_idx   = reg_addr[3:2];
    wire             gain_sel  = (region == cgo_pkg::GAIN_REGION);
    wire             offs_sel  = (region == cgo_pkg::OFFS_REGION);
    wire             ctrl_sel  = (reg_addr == cgo_pkg::CTRL_ADDR);
    wire             stat_sel  = (reg_addr == cgo_pkg::STAT_ADDR);
    wire             ctrl_wr   = reg_wr & ctrl_sel;
    wire             stat_wr   = reg_wr & stat_sel;

    // sample path timing
    //   edge n   : sample and channel sampled, result formed combinationally
    //   edge n+1 : out_valid high for one cycle, out_ch and out_data hold after
    //   edge n+1 : the channel's calibration estimate lands in its offset word
    // output uses the offset word as it stood before the sample's own update,
    // so a calibrating channel lags by one sample; cheaper than a bypass path
    // one shared datapath serves all four channels through operand selection

    // operand selection for the arriving sample
    assign cif.sample  = in_data;
    assign cif.offset  = offs_w[in_ch];
    assign cif.gain    = gain_w[in_ch];
    assign cif.gain_en = gain_en_r;
    assign cif.offs_en = offs_en_r;
    assign cif.shift   = shift_r;   // range kept by software, clamped anyway

    cgo_chan_calc u_calc (
        .c (cif)
    );

    // per-channel gain word, offset word and sticky saturation flag
    // each channel keeps its own state; the shared datapath means
    // at most one sample per cycle across all four channels
    // every flop below is gated by ce, so a low ce freezes words, flags,
    // control and outputs alike; strobes seen while frozen are lost
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        logic [23:0] gain_r;
        logic [23:0] offs_r;
        logic        sat_r;
        wire         hit     = in_valid & (in_ch == CHW'(g));
        wire         gain_wr = reg_wr & gain_sel & (reg_idx == CHW'(g));
        wire         offs_wr = reg_wr & offs_sel & (reg_idx == CHW'(g));

        // full 24-bit range accepted, no clipping on write
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                gain_r <= cgo_pkg::GAIN_RST;
            else if (ce && gain_wr)
                gain_r <= reg_wdata[23:0];
        end

        // software write wins over a calibration update in the same cycle
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                offs_r <= cgo_pkg::OFFS_RST;
            else if (ce)
            begin
                if (offs_wr)
                    offs_r <= reg_wdata[23:0];
                else if (cal_en_r && hit)
                    offs_r <= cif.cal_next;
            end
        end

        // new saturation beats a write-one clear
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                sat_r <= 1'b0;
            else if (ce)
            begin
                if (hit && cif.sat)
                    sat_r <= 1'b1;
                else if (stat_wr && reg_wdata[g])
                    sat_r <= 1'b0;
            end
        end

        assign gain_w[g] = gain_r;
        assign offs_w[g] = offs_r;
        assign sat_w[g]  = sat_r;
    end

    // control word; clearing the cal enable simply stops updates
    //   gain_correct_enable   in bit 0: gain scaling on the output
    //   offset_correct_enable in bit 1: offset subtraction on the output
    //   offset_cal_enable     in bit 2: offset words track the raw samples
    //   cal_feedback_shift    in 12:8 : loop step is the error shifted right this far
    // larger shifts give a slower, quieter loop; zero copies the sample outright
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gain_en_r <= 1'b0;
            offs_en_r <= 1'b0;
            cal_en_r  <= 1'b0;
            shift_r   <= 5'h00;
        end
        else if (ce && ctrl_wr)
        begin
            gain_en_r <= reg_wdata[cgo_pkg::GAIN_EN_BIT];
            offs_en_r <= reg_wdata[cgo_pkg::OFFS_EN_BIT];
            cal_en_r  <= reg_wdata[cgo_pkg::CAL_EN_BIT];
            shift_r   <= reg_wdata[cgo_pkg::SHIFT_LSB +: cgo_pkg::SHW];
        end
    end

    // read mux; unmapped addresses read zero
    // saturation flags are the only status; each collects clipped samples
    // of its channel until software writes a one to that flag's bit
    // reads have no side effect, so polling the status word is safe
    assign rdata_nxt = gain_sel ? {8'h00, gain_w[reg_idx]}
                     : offs_sel ? {8'h00, offs_w[reg_idx]}
                     : ctrl_sel ? {19'h00000, shift_r, 5'h00, cal_en_r, offs_en_r, gain_en_r}
                     : stat_sel ? {28'h0000000, sat_w}
                     : 32'h00000000;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_r <= 32'h00000000;
        else if (ce)
            rdata_r <= reg_rd ? rdata_nxt : 32'h00000000;
    end

    // arithmetic, for reference
    //   d   = offset enabled ? clip24(sample - offset) : sample
    //   out = gain enabled   ? clip24(d * gain / full positive code) : d
    // the divide truncates toward zero, so small negative results round up
    // a gain word at full positive code passes samples unchanged
    // clipping in either stage marks the channel's sticky flag

    // one register stage; output uses the offset before this sample's update
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_valid_r <= 1'b0;
            out_ch_r    <= 2'h0;
            out_data_r  <= 24'h000000;
        end
        else if (ce)
        begin
            out_valid_r <= in_valid;
            if (in_valid)
            begin
                out_ch_r   <= in_ch;
                out_data_r <= cif.result;
            end
        end
    end

    // outputs come straight from their flops, nothing after the last register
    // so downstream timing sees clock-to-out only
    assign reg_rdata = rdata_r;
    assign out_valid = out_valid_r;
    assign out_ch    = out_ch_r;
    assign out_data  = out_data_r;
endmodule : cgo_top
